// File: tb/cfg_software_model.sv
/*
 * configuration software model: issues one config access per call.
 * assumes the block samples a request on the rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module cfg_software_model
    import bridge_window_pkg::*;
(
    // clock
    input wire logic i_clk_sys,
    // configuration access
    output var cfg_req_t o_cfg
);
    initial o_cfg = '0;
    // one-cycle request; released lines carry inverted data so stale values are never read as good
    task automatic access(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge i_clk_sys);
        o_cfg <= '{1'b1, w, a, be, d};
        @(posedge i_clk_sys);
        o_cfg <= '{1'b0, 1'b0, ~a, ~be, ~d};
    endtask : access
endmodule : cfg_software_model
`default_nettype wire

// File: tb/test_bridge_window_upper_regs.sv
/*
 * self-checking bench for the upper window registers.
 * assumes the software model drives all config accesses.
 */
`timescale 1ns/1ps
`default_nettype none
module test_bridge_window_upper_regs import bridge_window_pkg::*; ();
    logic i_clk_sys = 1'b0;
    logic i_reset = 1'b1;
    cfg_req_t cfg;
    fwd_query_t query = '0;
    logic [11:0] pref_bottom_low = 12'h100;
    logic [15:0] io_bottom_low = 16'h5000;
    logic [15:0] io_top_low = 16'h3000;
    logic [31:0] rdata;
    logic hit, fwd, pend = 1'b0;
    logic [32:0] notes[$];
    logic [31:0] shadow[0:15];
    logic [63:0] pts[9] = '{64'h1_0fff_ffff, 64'h1_1000_0000, 64'h1_7fff_ffff, 64'h1_8000_0000,
        64'h1_4fff, 64'h1_5000, 64'h2_3fff, 64'h2_4000, 64'h1_0001_5000};
    int mismatches = 0;
    int compares = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    cfg_software_model sw_u (.i_clk_sys(i_clk_sys), .o_cfg(cfg));
    bridge_window_upper_regs dut_u (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cfg(cfg),
        .o_cfg_rdata(rdata), .o_cfg_hit(hit), .i_pref_bottom_low(pref_bottom_low),
        .i_io_bottom_low(io_bottom_low), .i_io_top_low(io_top_low), .i_query(query), .o_forward(fwd));
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic model_reset();
        foreach (shadow[i]) shadow[i] = 32'h0;
        shadow[9] = 32'h0001_0000;
    endtask : model_reset
    function automatic logic [31:0] wmask(input logic [7:0] a);
        case (a[7:2])
            6'h09: return 32'hfff0_0000;
            6'h0a, 6'h0b, 6'h0c: return 32'hffff_ffff;
            6'h0d: return 32'h0000_ffff;
            default: return 32'h0;
        endcase
    endfunction : wmask
    task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        logic [31:0] m;
        logic mapped;
        m = wmask(a) & {{8{~be[3]}}, {8{~be[2]}}, {8{~be[1]}}, {8{~be[0]}}};
        mapped = (a[7:2] >= 6'h09) && (a[7:2] <= 6'h0d);
        if (w) shadow[a[5:2]] = (shadow[a[5:2]] & ~m) | (d & m);
        notes.push_back({mapped, (w || !mapped) ? 32'h0 : shadow[a[5:2]]});
        sw_u.access(w, a, be, d);
    endtask : acc
    task automatic probe(input logic io, input logic [63:0] a);
        logic [63:0] lo, hi;
        lo = io ? {32'h0, shadow[12][15:0], io_bottom_low[15:12], 12'h000} : {shadow[10], pref_bottom_low, 20'h0};
        hi = io ? {32'h0, shadow[12][31:16], io_top_low[15:12], 12'hfff} : {shadow[11], shadow[9][31:20], 20'hfffff};
        @(posedge i_clk_sys);
        query <= '{1'b1, io, a};
        @(negedge i_clk_sys);
        check({32'h0, fwd}, {32'h0, a >= lo && a <= hi});
    endtask : probe
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : final_report
    // every result arrives one cycle after its request is driven
    always @(posedge i_clk_sys) pend <= cfg.valid;
    always @(negedge i_clk_sys) begin
        if (pend) check({hit, rdata}, notes.pop_front());
    end
    initial begin
        repeat (20000) @(posedge i_clk_sys);
        mismatches++;
        final_report();
    end
    initial begin
        void'($urandom(32'h83764fb6));
        model_reset();
        for (int r = 0; r < 2; r++) begin
            repeat (3) @(posedge i_clk_sys);
            i_reset <= 1'b0;
            model_reset();
            for (int i = 7; i < 15; i++) acc(1'b0, 8'(i * 4), 4'h0, 32'h0);
            acc(1'b1, 8'h24, 4'h0, 32'hffff_ffff);
            for (int i = 0; i < 40; i++) acc(1'($urandom), 8'($urandom_range(15) * 4), 4'($urandom), $urandom);
            for (int i = 9; i < 14; i++) acc(1'b0, 8'(i * 4), 4'h0, 32'h0);
            @(posedge i_clk_sys);
            i_reset <= 1'b1;
        end
        repeat (3) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        model_reset();
        acc(1'b1, 8'h28, 4'h0, 32'h1);
        acc(1'b1, 8'h2c, 4'h0, 32'h1);
        acc(1'b1, 8'h24, 4'h3, 32'h7ff0_0000);
        acc(1'b1, 8'h30, 4'h0, 32'h0002_0001);
        repeat (2) acc(1'b0, 8'h28, 4'h0, 32'h0);
        foreach (pts[i]) probe(i > 3, pts[i]);
        repeat (2) @(posedge i_clk_sys);
        final_report();
    end
endmodule : test_bridge_window_upper_regs
`default_nettype wire

// File: verilog/bridge_window_pkg.sv
/*
 * constants and carrier types for the bridge window upper registers.
 * assumes configuration dword accesses with active-low byte enables.
 */
package bridge_window_pkg;
    // dword addresses (byte offsets, bits 1:0 zero)
    localparam logic [7:0] DW_PREF_TOP_LOW = 8'h24;
    localparam logic [7:0] DW_PREF_BOTTOM_HIGH = 8'h28;
    localparam logic [7:0] DW_PREF_TOP_HIGH = 8'h2c;
    localparam logic [7:0] DW_IO_HIGH = 8'h30;
    localparam logic [7:0] DW_BOARD_MAKER = 8'h34;
    // printed register offsets
    localparam logic [7:0] OFS_PREF_TOP_LOW = 8'h26;
    localparam logic [7:0] OFS_IO_TOP_HIGH = 8'h32;
    // field layout and fixed values
    localparam int PREF_TOP_FIELD_LSB = 20;
    localparam int MEM_GRAIN_BITS = 20;
    localparam int IO_GRAIN_BITS = 12;
    localparam logic [3:0] WIDE_ADDR_FLAG = 4'h1;
    localparam logic [11:0] PREF_TOP_RESET = 12'h000;
    localparam logic [31:0] HIGH_RESET = 32'h0000_0000;
    localparam logic [15:0] HALF_RESET = 16'h0000;
    localparam logic [19:0] MEM_TOP_FILL = 20'hfffff;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
        logic [3:0] byte_en_n;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic valid;
        logic is_io;
        logic [63:0] addr;
    } fwd_query_t;
endpackage : bridge_window_pkg

// File: verilog/bridge_window_upper_regs.sv
/*
 * upper window registers of a bus bridge plus the window hit check that
 * uses them. assumes one configuration access per cycle, already decoded
 * as a type 0 access to this function; byte enables active low. the
 * lower bottom and io top fields come in from the neighbouring register block.
 */
// Overview of operation
// - top low register bits 19:16 read-only, return 1h (64-bit capable).
// - top bits 31:20 writable; lower 20 address bits assumed all ones.
// - memory windows aligned with one megabyte granularity.
// - 32-bit rw bottom address bits 63:32, reset zero.
// - 32-bit rw top address bits 63:32, reset zero.
// - prefetchable bounds decide memory read/write forwarding.
// - 16-bit rw io bottom address bits 31:16, reset zero.
// - 16-bit rw io top address bits 31:16, reset zero.
// - io window uses 4 KB alignment and granularity.
// - 16-bit rw board maker identifier, reset zero, optional by revision.
// - bottom bits 31:20 writable; lower 20 bits assumed zero.
`timescale 1ns/1ps
`default_nettype none
module bridge_window_upper_regs
    import bridge_window_pkg::*;
#(
    parameter bit HAS_BOARD_MAKER = 1'b1
) (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // configuration access
    input wire cfg_req_t i_cfg,
    output logic [31:0] o_cfg_rdata,
    output logic o_cfg_hit,
    // lower window fields kept elsewhere
    input wire logic [11:0] i_pref_bottom_low,
    input wire logic [15:0] i_io_bottom_low,
    input wire logic [15:0] i_io_top_low,
    // forwarding query
    input wire fwd_query_t i_query,
    output logic o_forward
);
    logic [11:0] pref_top;
    logic [31:0] pref_bottom_high;
    logic [31:0] pref_top_high;
    logic [15:0] io_bottom_high;
    logic [15:0] io_top_high;
    logic [15:0] board_maker;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be_n);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (!be_n[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    wire wr = i_cfg.valid && i_cfg.write;
    wire [7:0] dw = {i_cfg.addr[7:2], 2'b00};
    wire sel_top_low = dw == DW_PREF_TOP_LOW;
    wire sel_bot_high = dw == DW_PREF_BOTTOM_HIGH;
    wire sel_top_high = dw == DW_PREF_TOP_HIGH;
    wire sel_io = dw == DW_IO_HIGH;
    wire sel_maker = (dw == DW_BOARD_MAKER) && HAS_BOARD_MAKER;

    // images of each dword as read; the top-low dword shares its lower half with
    // the bottom-low register, which this block returns as zero
    wire [31:0] img_top_low = {pref_top, WIDE_ADDR_FLAG, 16'h0000};
    wire [31:0] img_io = {io_top_high, io_bottom_high};
    wire [31:0] img_maker = {16'h0000, board_maker};
    wire [31:0] new_top_low = merge(img_top_low, i_cfg.wdata, i_cfg.byte_en_n);
    wire [31:0] new_bot_high = merge(pref_bottom_high, i_cfg.wdata, i_cfg.byte_en_n);
    wire [31:0] new_top_high = merge(pref_top_high, i_cfg.wdata, i_cfg.byte_en_n);
    wire [31:0] new_io = merge(img_io, i_cfg.wdata, i_cfg.byte_en_n);
    wire [31:0] new_maker = merge(img_maker, i_cfg.wdata, i_cfg.byte_en_n);

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            pref_top <= PREF_TOP_RESET;
            pref_bottom_high <= HIGH_RESET;
            pref_top_high <= HIGH_RESET;
            io_bottom_high <= HALF_RESET;
            io_top_high <= HALF_RESET;
            board_maker <= HALF_RESET;
        end else if (wr) begin
            if (sel_top_low) begin
                pref_top <= new_top_low[31:PREF_TOP_FIELD_LSB];
            end
            if (sel_bot_high) begin
                pref_bottom_high <= new_bot_high;
            end
            if (sel_top_high) begin
                pref_top_high <= new_top_high;
            end
            if (sel_io) begin
                io_bottom_high <= new_io[15:0];
                io_top_high <= new_io[31:16];
            end
            if (sel_maker) begin
                board_maker <= new_maker[15:0];
            end
        end
    end

    // read data registered one cycle after the request
    wire [31:0] next_rdata = sel_top_low ? img_top_low :
                             sel_bot_high ? pref_bottom_high :
                             sel_top_high ? pref_top_high :
                             sel_io ? img_io :
                             sel_maker ? img_maker : 32'h0000_0000;
    wire next_hit = i_cfg.valid && (sel_top_low || sel_bot_high || sel_top_high || sel_io || sel_maker);

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_cfg_rdata <= 32'h0000_0000;
            o_cfg_hit <= 1'b0;
        end else begin
            o_cfg_rdata <= (i_cfg.valid && !i_cfg.write) ? next_rdata : 32'h0000_0000;
            o_cfg_hit <= next_hit;
        end
    end

    // register checks; apart from maker_reset_a, attempts that meet a reset edge are dropped by the disable
    flag_reads_one_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_cfg.valid && !i_cfg.write && sel_top_low |=> o_cfg_rdata[19:16] == WIDE_ADDR_FLAG)
        else $error("wide address flag not returned");
    top_low_read_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_cfg.valid && !i_cfg.write && sel_top_low |=> o_cfg_rdata[31:20] == $past(pref_top))
        else $error("top field not read back");
    top_low_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr && sel_top_low && !i_cfg.byte_en_n[3] |=> pref_top[11:4] == $past(i_cfg.wdata[31:24]))
        else $error("top low field not written");
    top_nibble_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr && sel_top_low && !i_cfg.byte_en_n[2] |=> pref_top[3:0] == $past(i_cfg.wdata[23:20]))
        else $error("top low nibble not written");
    top_low_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !(wr && sel_top_low) |=> $stable(pref_top))
        else $error("top field changed without write");
    bot_high_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr && sel_bot_high && i_cfg.byte_en_n == 4'h0 |=> pref_bottom_high == $past(i_cfg.wdata))
        else $error("bottom high not written");
    bot_high_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !(wr && sel_bot_high) |=> $stable(pref_bottom_high))
        else $error("bottom high changed without write");
    top_high_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr && sel_top_high && i_cfg.byte_en_n == 4'h0 |=> pref_top_high == $past(i_cfg.wdata))
        else $error("top high not written");
    top_high_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !(wr && sel_top_high) |=> $stable(pref_top_high))
        else $error("top high changed without write");
    io_bottom_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr && sel_io && i_cfg.byte_en_n[1:0] == 2'b00 |=> io_bottom_high == $past(i_cfg.wdata[15:0]))
        else $error("io bottom high not written");
    io_top_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr && sel_io && i_cfg.byte_en_n[3:2] == 2'b00 |=> io_top_high == $past(i_cfg.wdata[31:16]))
        else $error("io top high not written");
    io_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !(wr && sel_io) |=> $stable(io_bottom_high) && $stable(io_top_high))
        else $error("io high halves changed without write");
    io_read_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_cfg.valid && !i_cfg.write && sel_io |=> o_cfg_rdata == $past({io_top_high, io_bottom_high}))
        else $error("io high halves not read back");
    maker_reset_a: assert property (@(posedge i_clk_sys)
        i_reset |=> board_maker == HALF_RESET)
        else $error("board maker not cleared");
    maker_write_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        wr && sel_maker && i_cfg.byte_en_n[1:0] == 2'b00 |=> board_maker == $past(i_cfg.wdata[15:0]))
        else $error("board maker not written");
    maker_hold_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !(wr && sel_maker) |=> $stable(board_maker))
        else $error("board maker changed without write");
    maker_read_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_cfg.valid && !i_cfg.write && sel_maker |=> o_cfg_rdata == {16'h0000, $past(board_maker)})
        else $error("board maker not read back");

    // assembled bounds; fixed low fills give megabyte and 4 KB steps
    wire [63:0] mem_bottom = {pref_bottom_high, i_pref_bottom_low, {MEM_GRAIN_BITS{1'b0}}};
    wire [63:0] mem_top = {pref_top_high, pref_top, MEM_TOP_FILL};
    wire [31:0] io_bottom = {io_bottom_high, i_io_bottom_low[15:IO_GRAIN_BITS], {IO_GRAIN_BITS{1'b0}}};
    wire [31:0] io_top = {io_top_high, i_io_top_low[15:IO_GRAIN_BITS], {IO_GRAIN_BITS{1'b1}}};
    wire mem_in = (i_query.addr >= mem_bottom) && (i_query.addr <= mem_top);
    wire io_in = (i_query.addr[63:32] == 32'h0000_0000) &&
                 (i_query.addr[31:0] >= io_bottom) && (i_query.addr[31:0] <= io_top);

    // combinational so the decode sits in the same cycle as the address phase
    assign o_forward = i_query.valid && (i_query.is_io ? io_in : mem_in);

    // decode checks; the query path is combinational, so these hold in the same cycle
    query_idle_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        !i_query.valid |-> !o_forward)
        else $error("idle query forwarded");
    mem_bounds_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_query.valid && !i_query.is_io && i_query.addr == mem_top && mem_bottom <= mem_top |-> o_forward)
        else $error("top address not forwarded");
    mem_bottom_in_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_query.valid && !i_query.is_io && i_query.addr == mem_bottom && mem_bottom <= mem_top |-> o_forward)
        else $error("bottom address not forwarded");
    mem_grain_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_query.valid && !i_query.is_io && i_query.addr[63:20] == mem_top[63:20] &&
        mem_bottom <= mem_top |-> o_forward)
        else $error("top megabyte not forwarded");
    mem_below_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_query.valid && !i_query.is_io && i_query.addr < mem_bottom |-> !o_forward)
        else $error("address below window forwarded");
    mem_above_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_query.valid && !i_query.is_io && i_query.addr > mem_top |-> !o_forward)
        else $error("address above window forwarded");
    io_grain_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_query.valid && i_query.is_io && i_query.addr[63:12] == {32'h0000_0000, io_top[31:IO_GRAIN_BITS]} &&
        io_bottom <= io_top |-> o_forward)
        else $error("io top page not forwarded whole");
    io_bottom_in_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_query.valid && i_query.is_io && i_query.addr == {32'h0000_0000, io_bottom} &&
        io_bottom <= io_top |-> o_forward)
        else $error("io bottom address not forwarded");
    io_above_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_query.valid && i_query.is_io && i_query.addr > {32'h0000_0000, io_top} |-> !o_forward)
        else $error("io address above window forwarded");
    io_upper_a: assert property (@(posedge i_clk_sys) disable iff (i_reset)
        i_query.valid && i_query.is_io && i_query.addr[63:32] != 32'h0000_0000 |-> !o_forward)
        else $error("io address beyond 32 bits forwarded");
endmodule : bridge_window_upper_regs
`default_nettype wire
